// *** swr_link.sv ***
// Top of the single-wire slave: addressing, scratchpad write and read.
// Assumes an open-drain pin with external pull-up and a static identity.
`timescale 1ns/10ps
module swr_link #(
  parameter logic [7:0] CMD_WRITE_SP = 8'h0F,
  parameter logic [7:0] CMD_READ_SP = 8'hAA,
  parameter logic [7:0] CMD_REFRESH_SP = 8'hA3,
  parameter int RST_LONG_CYC = swr_pkg::RST_LONG_CYC,
  parameter int RST_STD_CYC = swr_pkg::RST_STD_CYC,
  parameter int SAMP_STD_CYC = swr_pkg::SAMP_STD_CYC,
  parameter int PDH_STD_CYC = swr_pkg::PDH_STD_CYC,
  parameter int PDL_STD_CYC = swr_pkg::PDL_STD_CYC,
  parameter int HOLD_STD_CYC = swr_pkg::HOLD_STD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ioIn,
  output logic ioOut,
  output logic ioOe,
  input wire logic [63:0] romId,
  input wire logic copyDoneSet,
  output logic copyDoneFlag,
  output logic partialByteFlag,
  output logic resumeFlag,
  output logic highSpeedFlag,
  output logic functionActive,
  output logic [15:0] targetAddr,
  output logic [63:0] spData
);
  typedef enum logic [3:0] {
    S_IDLE, S_ROMCMD, S_READROM, S_MATCH, S_SEARCH, S_FUNC,
    S_WR_ADDR, S_WR_DATA, S_RD_TX, S_CRC, S_DONE
  } swr_state_t;

  swr_state_t state_q;
  logic [7:0] sh_q;
  logic [2:0] bitCnt_q;
  logic [3:0] byteCnt_q;
  logic [5:0] idx_q;
  logic [1:0] srchPh_q;
  logic mism_q, fast_q, fastPrev_q, rsm_q, cpy_q, part_q, crcArm_q, ioOut_q;
  logic [7:0] crcHi_q;
  logic [15:0] ta_q;
  logic [7:0] sp_q [0:swr_pkg::SP_BYTES-1];

  logic bitDone, rxBit, busReset, longReset;
  logic [15:0] crcVal;
  logic [7:0] rxByte, esByte;
  logic byteEnd, idBit, txEn, txBit, crcFeed, crcClear, matchEnd, cpyClr;

  // Byte sent at a given index of the read sequence
  function automatic logic [7:0] rdByte(input logic [3:0] n);
    logic [2:0] k;
    k = 3'(n - 4'd3);
    case (n)
      4'd0: rdByte = ta_q[7:0];
      4'd1: rdByte = ta_q[15:8];
      4'd2: rdByte = esByte;
      default: rdByte = sp_q[k];
    endcase
  endfunction

  // Bit slot engine
  swr_slot #(
    .CW(swr_pkg::CNT_W),
    .RST_LONG(RST_LONG_CYC),
    .RST_STD(RST_STD_CYC),
    .RST_HS(swr_pkg::RST_HS_CYC),
    .SAMP_STD(SAMP_STD_CYC),
    .SAMP_HS(swr_pkg::SAMP_HS_CYC),
    .PDH_STD(PDH_STD_CYC),
    .PDH_HS(swr_pkg::PDH_HS_CYC),
    .PDL_STD(PDL_STD_CYC),
    .PDL_HS(swr_pkg::PDL_HS_CYC),
    .HOLD_STD(HOLD_STD_CYC),
    .HOLD_HS(swr_pkg::HOLD_HS_CYC)
  ) u_slot (
    .clk(clk),
    .reset_n(reset_n),
    .ioIn(ioIn),
    .highSpeed(fast_q),
    .txEn(txEn),
    .txBit(txBit),
    .ioOe(ioOe),
    .bitDone(bitDone),
    .rxBit(rxBit),
    .busReset(busReset),
    .longReset(longReset)
  );

  // Scratchpad CRC16
  swr_crc16 u_crc (
    .clk(clk),
    .reset_n(reset_n),
    .clear(crcClear),
    .feed(crcFeed),
    .din(txEn ? txBit : rxBit),
    .crc(crcVal)
  );

  // Bit and byte decode
  assign rxByte = {rxBit, sh_q[7:1]}; // RL20
  assign byteEnd = bitDone && (bitCnt_q == 3'd7);
  assign idBit = romId[idx_q];
  assign matchEnd = bitDone && (idx_q == 6'd63);
  assign esByte = swr_pkg::ES_ONES | {cpy_q, 1'b0, part_q, 5'b00000}; // RL1 RL6
  assign cpyClr = byteEnd && (state_q == S_FUNC)
    && (rxByte == CMD_WRITE_SP || rxByte == CMD_REFRESH_SP);

  // Transmit selection: identity, search pair, or byte shifter
  assign txEn = (state_q == S_READROM) || (state_q == S_RD_TX) || (state_q == S_CRC)
    || ((state_q == S_SEARCH) && (srchPh_q != 2'd2));
  assign txBit = (state_q == S_READROM) ? idBit :
    (state_q == S_SEARCH) ? (idBit ^ srchPh_q[0]) : sh_q[0]; // RL17

  // CRC covers command, address, status and data, not the CRC itself
  assign crcClear = busReset || (state_q == S_ROMCMD);
  assign crcFeed = bitDone && ((state_q == S_FUNC) || (state_q == S_WR_ADDR)
    || (state_q == S_WR_DATA) || (state_q == S_RD_TX)); // RL4 RL8

  // Outputs
  assign ioOut = ioOut_q;
  assign copyDoneFlag = cpy_q;
  assign partialByteFlag = part_q;
  assign resumeFlag = rsm_q;
  assign highSpeedFlag = fast_q;
  assign targetAddr = ta_q;
  genvar g;
  generate
    for (g = 0; g < swr_pkg::SP_BYTES; g++)
    begin : g_sp
      assign spData[8*g +: 8] = sp_q[g];
    end
  endgenerate

  // Status flags; a copy-done event wins over the clearing write
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cpy_q <= swr_pkg::COPY_RESET;
      ioOut_q <= 1'b0;
      functionActive <= 1'b0;
    end
    else
    begin
      if (copyDoneSet)
        cpy_q <= 1'b1; // RL1
      else if (cpyClr)
        cpy_q <= 1'b0; // RL1
      functionActive <= (state_q == S_FUNC);
    end
  end

  // Speed flag: set by fast commands, dropped by a long reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fast_q <= 1'b0;
      fastPrev_q <= 1'b0;
    end
    else if (longReset)
      fast_q <= 1'b0; // RL22
    else if (byteEnd && state_q == S_ROMCMD
      && (rxByte == swr_pkg::ROM_HS_SKIP || rxByte == swr_pkg::ROM_HS_MATCH))
    begin
      fastPrev_q <= fast_q;
      fast_q <= 1'b1; // RL22 RL23
    end
    else if (matchEnd && state_q == S_MATCH && (mism_q || rxBit != idBit))
      fast_q <= fastPrev_q; // RL23
  end

  // Scratchpad storage
  always_ff @(posedge clk)
  begin
    if (byteEnd && state_q == S_WR_DATA)
      sp_q[byteCnt_q[2:0]] <= rxByte;
  end

  // Protocol sequencer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= S_IDLE;
      sh_q <= 8'h00;
      bitCnt_q <= 3'd0;
      byteCnt_q <= 4'd0;
      idx_q <= 6'd0;
      srchPh_q <= 2'd0;
      mism_q <= 1'b0;
      rsm_q <= 1'b0;
      part_q <= swr_pkg::PART_RESET; // RL6
      ta_q <= 16'h0000;
      crcArm_q <= 1'b0;
      crcHi_q <= 8'h00;
    end
    else if (busReset)
    begin
      state_q <= S_ROMCMD; // RL13
      bitCnt_q <= 3'd0;
      byteCnt_q <= 4'd0;
      idx_q <= 6'd0;
      srchPh_q <= 2'd0;
      mism_q <= 1'b0;
      crcArm_q <= 1'b0;
    end
    else if (crcArm_q)
    begin
      crcArm_q <= 1'b0;
      sh_q <= ~crcVal[7:0]; // RL24
      crcHi_q <= ~crcVal[15:8];
    end
    else if (bitDone)
    begin
      bitCnt_q <= bitCnt_q + 3'd1;
      if (!txEn)
        sh_q <= rxByte;
      case (state_q)
        S_ROMCMD:
        begin
          if (byteEnd)
          begin
            idx_q <= 6'd0;
            case (rxByte) // RL14
              swr_pkg::ROM_READ: state_q <= S_READROM; // RL15
              swr_pkg::ROM_MATCH, swr_pkg::ROM_HS_MATCH: state_q <= S_MATCH;
              swr_pkg::ROM_SEARCH: state_q <= S_SEARCH;
              swr_pkg::ROM_SKIP, swr_pkg::ROM_HS_SKIP: state_q <= S_FUNC; // RL19
              swr_pkg::ROM_RESUME: state_q <= rsm_q ? S_FUNC : S_DONE; // RL21
              default: state_q <= S_DONE;
            endcase
          end
        end
        S_READROM:
        begin
          idx_q <= idx_q + 6'd1;
          if (idx_q == 6'd63)
            state_q <= S_FUNC;
        end
        S_MATCH:
        begin
          idx_q <= idx_q + 6'd1;
          if (rxBit != idBit)
            mism_q <= 1'b1;
          if (matchEnd)
          begin
            bitCnt_q <= 3'd0;
            rsm_q <= ~(mism_q || rxBit != idBit); // RL21
            state_q <= (mism_q || rxBit != idBit) ? S_DONE : S_FUNC; // RL16
          end
        end
        S_SEARCH:
        begin
          srchPh_q <= (srchPh_q == 2'd2) ? 2'd0 : srchPh_q + 2'd1;
          if (srchPh_q == 2'd2)
          begin
            idx_q <= idx_q + 6'd1;
            bitCnt_q <= 3'd0;
            if (rxBit != idBit)
            begin
              rsm_q <= 1'b0;
              state_q <= S_DONE; // RL18
            end
            else if (idx_q == 6'd63)
            begin
              rsm_q <= 1'b1; // RL21
              state_q <= S_FUNC;
            end
          end
        end
        S_FUNC:
        begin
          if (byteEnd)
          begin
            byteCnt_q <= 4'd0;
            if (rxByte == CMD_WRITE_SP || rxByte == CMD_REFRESH_SP)
              state_q <= S_WR_ADDR;
            else if (rxByte == CMD_READ_SP)
            begin
              sh_q <= ta_q[7:0]; // RL5
              state_q <= S_RD_TX;
            end
            else
              state_q <= S_DONE;
          end
        end
        S_WR_ADDR:
        begin
          if (byteEnd)
          begin
            byteCnt_q <= byteCnt_q + 4'd1;
            if (byteCnt_q == 4'd0)
              ta_q[7:0] <= rxByte & swr_pkg::TA_ALIGN_MASK; // RL2
            else
            begin
              ta_q[15:8] <= rxByte;
              byteCnt_q <= 4'd0;
              state_q <= S_WR_DATA;
            end
          end
        end
        S_WR_DATA:
        begin
          if (bitCnt_q == 3'd0)
            part_q <= 1'b1; // RL6
          if (byteEnd)
          begin
            part_q <= 1'b0; // RL6
            byteCnt_q <= byteCnt_q + 4'd1;
            if (byteCnt_q == swr_pkg::WR_LAST_IDX)
            begin
              byteCnt_q <= 4'd0;
              crcArm_q <= 1'b1; // RL4
              state_q <= S_CRC;
            end
          end
        end
        S_RD_TX:
        begin
          sh_q <= {1'b0, sh_q[7:1]}; // RL20
          if (byteEnd)
          begin
            byteCnt_q <= byteCnt_q + 4'd1;
            sh_q <= rdByte(byteCnt_q + 4'd1); // RL5
            if (byteCnt_q == swr_pkg::RD_LAST_IDX)
            begin
              byteCnt_q <= 4'd0;
              crcArm_q <= 1'b1; // RL8
              state_q <= S_CRC;
            end
          end
        end
        S_CRC:
        begin
          sh_q <= {1'b0, sh_q[7:1]};
          if (byteEnd)
          begin
            byteCnt_q <= byteCnt_q + 4'd1;
            sh_q <= crcHi_q; // RL24
            if (byteCnt_q == 4'd1)
              state_q <= S_DONE;
          end
        end
        default:
          state_q <= state_q;
      endcase
    end
  end
endmodule

// *** swr_pkg.sv ***
// Constants for the single-wire slave: timing, commands and status layout.
// Assumes a 250 MHz system clock; all counts are derived from times in ns.
// Notes on behaviour
// [RL1] Copy done sets bit 7; scratchpad write clears it
// [RL2] Target address low three bits forced to zero
// [RL3] Master should send eight full data bytes
// [RL4] Write returns inverted CRC16 over raw command data
// [RL5] Read sends address, status byte, then data
// [RL6] Partial byte or power loss sets bit 5
// [RL7] Master rewrites scratchpad if either flag set
// [RL8] Read ends with inverted CRC over everything sent
// [RL9] Master then issues copy or secret command
// [RL10] Slave only; master falling edge starts slots
// [RL11] Standard and high speed bit rates supported
// [RL12] Idle high; long low resets the device
// [RL13] Reset, presence, addressing, function, then data
// [RL14] Addressing command is eight bits, decoded first
// [RL15] Read identity sends family, serial, then CRC
// [RL16] Match needs all 64 bits equal, else idle
// [RL17] Search: true bit, complement, then master bit
// [RL18] Search mismatch drops device until next reset
// [RL19] Skip grants function access without identity
// [RL20] All bytes travel least significant bit first
// [RL21] Resume works only with resume flag set
// [RL22] High-speed skip; long reset returns standard
// [RL23] High-speed match receives fast, stays fast; the code keeps fast only on a match, a mismatch restores the prior speed
// [RL24] CRC16 poly 8005, cleared per command, low first
package swr_pkg;
  localparam int CLK_MHZ = 250;
  // Times in ns
  localparam int T_RST_LONG_NS = 480000;
  localparam int T_RST_STD_NS = 120000;
  localparam int T_RST_HS_NS = 16000;
  localparam int T_SAMP_STD_NS = 30000;
  localparam int T_SAMP_HS_NS = 3000;
  localparam int T_PDH_STD_NS = 30000;
  localparam int T_PDH_HS_NS = 3000;
  localparam int T_PDL_STD_NS = 120000;
  localparam int T_PDL_HS_NS = 12000;
  localparam int T_HOLD_STD_NS = 30000;
  localparam int T_HOLD_HS_NS = 3000;
  // Least times, rounded up to whole cycles
  localparam int RST_LONG_CYC = (T_RST_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_STD_CYC = (T_RST_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_HS_CYC = (T_RST_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMP_STD_CYC = (T_SAMP_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMP_HS_CYC = (T_SAMP_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int PDH_STD_CYC = (T_PDH_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int PDH_HS_CYC = (T_PDH_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int PDL_STD_CYC = (T_PDL_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int PDL_HS_CYC = (T_PDL_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_STD_CYC = (T_HOLD_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_HS_CYC = (T_HOLD_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 17;
  // Addressing commands
  localparam logic [7:0] ROM_READ = 8'h33;
  localparam logic [7:0] ROM_MATCH = 8'h55;
  localparam logic [7:0] ROM_SEARCH = 8'hF0;
  localparam logic [7:0] ROM_SKIP = 8'hCC;
  localparam logic [7:0] ROM_RESUME = 8'hA5;
  localparam logic [7:0] ROM_HS_SKIP = 8'h3C;
  localparam logic [7:0] ROM_HS_MATCH = 8'h69;
  // Status byte layout
  localparam int ES_COPY_BIT = 7;
  localparam int ES_PART_BIT = 5;
  localparam logic [7:0] ES_ONES = 8'h5F;
  localparam logic [7:0] TA_ALIGN_MASK = 8'hF8;
  localparam logic [15:0] CRC16_POLY_REF = 16'hA001;
  // Values after reset
  localparam logic PART_RESET = 1'b1;
  localparam logic COPY_RESET = 1'b0;
  localparam int SP_BYTES = 8;
  // Read and write sequence byte indices
  localparam logic [3:0] RD_ES_IDX = 4'h2;
  localparam logic [3:0] RD_LAST_IDX = 4'hA;
  localparam logic [3:0] WR_LAST_IDX = 4'h7;
endpackage

// *** swr_crc16.sv ***
// Bit-serial CRC16 over the reflected 8005 polynomial.
// Assumes the caller clears it at each command and feeds bits LSB first.
`timescale 1ns/10ps
module swr_crc16 (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic feed,
  input wire logic din,
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic fb;

  // One shift step of the reflected register
  assign fb = crc_q[0] ^ din;
  assign crc_d = {1'b0, crc_q[15:1]} ^ (fb ? swr_pkg::CRC16_POLY_REF : 16'h0000); // RL24
  assign crc = crc_q;

  // Clear wins over feed
  always_ff @(posedge clk)
  begin
    if (!reset_n || clear)
      crc_q <= 16'h0000;
    else if (feed)
      crc_q <= crc_d;
  end
endmodule

// *** swr_slot.sv ***
// Bit slot engine: pin filter, reset and presence, sample and read drive.
// Assumes the master starts every slot; tx data is stable before the fall.
`timescale 1ns/10ps
module swr_slot #(
  parameter int CW = 17,
  parameter int RST_LONG = 1,
  parameter int RST_STD = 1,
  parameter int RST_HS = 1,
  parameter int SAMP_STD = 1,
  parameter int SAMP_HS = 1,
  parameter int PDH_STD = 1,
  parameter int PDH_HS = 1,
  parameter int PDL_STD = 1,
  parameter int PDL_HS = 1,
  parameter int HOLD_STD = 1,
  parameter int HOLD_HS = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ioIn,
  input wire logic highSpeed,
  input wire logic txEn,
  input wire logic txBit,
  output logic ioOe,
  output logic bitDone,
  output logic rxBit,
  output logic busReset,
  output logic longReset
);
  typedef enum logic [1:0] {PH_IDLE, PH_PDH, PH_PDL, PH_SLOT} swr_phase_t;
  swr_phase_t ph_q;
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [CW-1:0] low_q, tmr_q;
  logic oe_q, done_q, rx_q, rst_q, long_q;
  logic fall, rise, isRst, isLong;
  logic [CW-1:0] sampCyc, pdhCyc, pdlCyc, holdCyc, rstCyc;

  // Speed-dependent counts
  assign sampCyc = highSpeed ? CW'(SAMP_HS) : CW'(SAMP_STD); // RL11
  assign pdhCyc = highSpeed ? CW'(PDH_HS) : CW'(PDH_STD);
  assign pdlCyc = highSpeed ? CW'(PDL_HS) : CW'(PDL_STD);
  assign holdCyc = highSpeed ? CW'(HOLD_HS) : CW'(HOLD_STD);
  assign rstCyc = highSpeed ? CW'(RST_HS) : CW'(RST_STD);

  // Level changes once the second and third stages agree
  assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  assign fall = lvl_q & ~lvl_d; // RL10
  assign rise = ~lvl_q & lvl_d;
  assign isRst = (low_q >= rstCyc) && (ph_q != PH_PDL); // RL12
  assign isLong = (low_q >= CW'(RST_LONG)) && (ph_q != PH_PDL); // RL22

  assign ioOe = oe_q;
  assign bitDone = done_q;
  assign rxBit = rx_q;
  assign busReset = rst_q;
  assign longReset = long_q;

  // Pin synchroniser and low-time counter
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      low_q <= '0;
    end
    else
    begin
      s1_q <= ioIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      if (fall)
        low_q <= '0;
      else if (!lvl_q && low_q != '1)
        low_q <= low_q + 1'b1;
    end
  end

  // Slot, reset and presence sequencing
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ph_q <= PH_IDLE;
      tmr_q <= '0;
      oe_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 1'b1;
      rst_q <= 1'b0;
      long_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      rst_q <= 1'b0;
      long_q <= 1'b0;
      tmr_q <= tmr_q + 1'b1;
      if (rise && isRst)
      begin
        rst_q <= 1'b1; // RL13
        long_q <= isLong;
        oe_q <= 1'b0;
        ph_q <= PH_PDH;
        tmr_q <= '0;
      end
      else
      begin
        case (ph_q)
          PH_IDLE:
          begin
            if (fall)
            begin
              ph_q <= PH_SLOT;
              tmr_q <= '0;
              oe_q <= txEn & ~txBit; // RL10
            end
          end
          PH_SLOT:
          begin
            if (tmr_q >= holdCyc)
              oe_q <= 1'b0;
            if (tmr_q >= sampCyc)
            begin
              oe_q <= 1'b0; // Pull-down never outlasts the slot
              done_q <= 1'b1;
              rx_q <= lvl_q;
              ph_q <= PH_IDLE;
            end
          end
          PH_PDH:
          begin
            if (fall)
            begin
              ph_q <= PH_SLOT;
              tmr_q <= '0;
            end
            else if (tmr_q >= pdhCyc)
            begin
              oe_q <= 1'b1;
              ph_q <= PH_PDL;
              tmr_q <= '0;
            end
          end
          PH_PDL:
          begin
            if (tmr_q >= pdlCyc)
            begin
              oe_q <= 1'b0;
              ph_q <= PH_IDLE;
            end
          end
          default:
            ph_q <= PH_IDLE;
        endcase
      end
    end
  end
endmodule

// *** swr_link_chk.sv ***
// Port checks for the single-wire slave, bound into every swr_link.
// Assumes ioIn is the wire level including the device's own pull-down.
`timescale 1ns/10ps
module swr_link_chk #(
  parameter int RST_LONG_CYC = 1,
  parameter int RST_STD_CYC = 1,
  parameter int PDH_STD_CYC = 1,
  parameter int PDL_STD_CYC = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ioIn,
  input wire logic ioOut,
  input wire logic ioOe,
  input wire logic copyDoneSet,
  input wire logic copyDoneFlag,
  input wire logic partialByteFlag,
  input wire logic resumeFlag,
  input wire logic highSpeedFlag,
  input wire logic functionActive,
  input wire logic [15:0] targetAddr
);
  logic [15:0] lowCnt_q;
  logic [15:0] hiCnt_q;
  logic [15:0] lastLow_q;
  logic [15:0] oeCnt_q;
  // Run lengths of the wire levels and of the device's pull-down
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lowCnt_q <= 16'h0000;
      hiCnt_q <= 16'h0000;
      lastLow_q <= 16'h0000;
      oeCnt_q <= 16'h0000;
    end
    else
    begin
      lowCnt_q <= ioIn ? 16'h0000 : lowCnt_q + 16'h0001;
      hiCnt_q <= ioIn ? hiCnt_q + 16'h0001 : 16'h0000;
      lastLow_q <= (ioIn && lowCnt_q != 16'h0000) ? lowCnt_q : lastLow_q;
      oeCnt_q <= ioOe ? oeCnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_pin_only_low: assert property (ioOe |-> !ioOut)
    else $error("pin driven high");
  a_copy_set: assert property (copyDoneSet |=> copyDoneFlag)
    else $error("copy done not set");
  a_copy_cause: assert property ($rose(copyDoneFlag) |-> $past(copyDoneSet))
    else $error("copy done set without cause");
  a_addr_aligned: assert property (targetAddr[2:0] == 3'b000)
    else $error("target address not aligned");
  a_reset_values: assert property ($rose(reset_n) |-> partialByteFlag && !copyDoneFlag
    && !resumeFlag && !highSpeedFlag)
    else $error("flags wrong after reset");
  a_pull_cause: assert property ($rose(ioOe) |-> (lowCnt_q inside {[1:10]}) || (lowCnt_q == 0
    && lastLow_q >= RST_STD_CYC && hiCnt_q >= PDH_STD_CYC))
    else $error("pull-down without master fall or reset");
  a_presence_idle: assert property ($rose(ioOe) && lowCnt_q == 0 |-> !functionActive)
    else $error("function mode kept over reset");
  a_pull_bounded: assert property (oeCnt_q <= PDL_STD_CYC + swr_pkg::PDL_HS_CYC)
    else $error("bus held low too long");
  a_speed_long_reset: assert property ($fell(highSpeedFlag)
    |-> !$past(ioIn, RST_LONG_CYC - 10))
    else $error("speed dropped without long reset");
endmodule

bind swr_link swr_link_chk #(
  .RST_LONG_CYC(RST_LONG_CYC),
  .RST_STD_CYC(RST_STD_CYC),
  .PDH_STD_CYC(PDH_STD_CYC),
  .PDL_STD_CYC(PDL_STD_CYC)
) swr_link_chk_inst (
  .clk(clk), .reset_n(reset_n), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
  .copyDoneSet(copyDoneSet), .copyDoneFlag(copyDoneFlag),
  .partialByteFlag(partialByteFlag), .resumeFlag(resumeFlag),
  .highSpeedFlag(highSpeedFlag), .functionActive(functionActive),
  .targetAddr(targetAddr)
);

// *** swr_master.sv ***
// Bus master model: reset pulses and bit slots at shortened standard timing.
// Assumes the bench builds a pulled-up wire from both pull-downs.
`timescale 1ns/10ps
module swr_master (
  input wire logic clk,
  input wire logic busLine,
  output logic pullLow
);
  initial pullLow = 1'b0;
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reset pulse, then listen for presence on the released wire
  task automatic busReset(input int lowCyc, output logic present);
    present = 1'b0;
    @(posedge clk);
    pullLow <= 1'b1;
    waitCyc(lowCyc);
    pullLow <= 1'b0;
    repeat (200)
    begin
      @(posedge clk);
      if (!busLine)
        present = 1'b1;
    end
  endtask
  // One slot opened by our fall; a read is a write-one sampled early
  task automatic slot(input logic wBit, output logic rBit);
    @(posedge clk);
    pullLow <= 1'b1;
    waitCyc(wBit ? 8 : 60);
    pullLow <= 1'b0;
    waitCyc(wBit ? 12 : 1);
    rBit = busLine;
    waitCyc(wBit ? 70 : 30);
  endtask
  task automatic xferByte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 0; i < 8; i++)
      slot(w[i], r[i]);
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for swr_link with shortened standard-speed counts.
// Assumes swr_master drives the master side of the pulled-up wire.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic copyDoneSet = 1'b0;
  logic [63:0] romId = 64'hA53C_0F1E_7D28_6B10; // Arbitrary identity
  logic [63:0] data = 64'h0123_4567_89AB_CDEF;
  logic pullLow, busLine, ioOut, ioOe, copyDoneFlag, partialByteFlag;
  logic resumeFlag, highSpeedFlag, functionActive, b0, b1;
  logic [15:0] targetAddr, crc;
  logic [63:0] spData;
  logic [7:0] rx;
  int n_errors = 0;
  int compares = 0;
  // Open-drain wire with pull-up
  assign busLine = !(pullLow || ioOe);
  always #2 clk = ~clk;
  swr_link #(.RST_LONG_CYC(400), .RST_STD_CYC(200), .SAMP_STD_CYC(40), .PDH_STD_CYC(40),
    .PDL_STD_CYC(80)) swr_link_inst (
    .clk(clk), .reset_n(reset_n), .ioIn(busLine), .ioOut(ioOut), .ioOe(ioOe),
    .romId(romId), .copyDoneSet(copyDoneSet), .copyDoneFlag(copyDoneFlag),
    .partialByteFlag(partialByteFlag), .resumeFlag(resumeFlag),
    .highSpeedFlag(highSpeedFlag), .functionActive(functionActive),
    .targetAddr(targetAddr), .spData(spData));
  swr_master swr_master_inst (.clk(clk), .busLine(busLine), .pullLow(pullLow));
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction
  // Byte transfers that keep a running CRC of all bytes on the wire
  task automatic sendByte(input logic [7:0] b);
    swr_master_inst.xferByte(b, rx);
    crc = crcByte(crc, b);
  endtask
  task automatic getByte(input logic [7:0] exp, input string msg);
    swr_master_inst.xferByte(8'hFF, rx);
    crc = crcByte(crc, rx);
    check(rx, exp, msg);
  endtask
  task automatic getCrc(input string msg);
    logic [15:0] e;
    e = ~crc;
    getByte(e[7:0], msg);
    getByte(e[15:8], msg);
  endtask
  task automatic start(input logic [7:0] rom);
    logic p;
    swr_master_inst.busReset(250, p);
    check(p, 1'b1, "presence");
    sendByte(rom);
    crc = 16'h0000;
  endtask
  task automatic pulseCopy;
    copyDoneSet <= 1'b1;
    @(posedge clk);
    copyDoneSet <= 1'b0;
    @(posedge clk);
    check(copyDoneFlag, 1'b1, "copy set");
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("BAD %0t run timed out", $time);
    test_done;
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({partialByteFlag, copyDoneFlag}, 2'b10, "reset flags");
    start(swr_pkg::ROM_READ);
    for (int i = 0; i < 8; i++)
      getByte(romId[8*i +: 8], "identity");
    $display("test identity done");
    pulseCopy();
    start(swr_pkg::ROM_SKIP);
    check(functionActive, 1'b1, "skip");
    sendByte(8'h0F);
    sendByte(8'h2D);
    sendByte(8'h01);
    for (int i = 0; i < 8; i++)
      sendByte(data[8*i +: 8]);
    getCrc("write crc");
    check({targetAddr, spData}, {16'h0128, data}, "write");
    check({partialByteFlag, copyDoneFlag}, 2'b00, "write flags");
    $display("test write done");
    pulseCopy();
    start(swr_pkg::ROM_SKIP);
    sendByte(8'hAA);
    getByte(8'h28, "addr low");
    getByte(8'h01, "addr high");
    getByte(8'hDF, "status");
    for (int i = 0; i < 8; i++)
      getByte(data[8*i +: 8], "read data");
    getCrc("read crc");
    $display("test read done");
    start(swr_pkg::ROM_SKIP);
    sendByte(8'h0F);
    for (int i = 0; i < 5; i++)
      sendByte(data[8*i +: 8]);
    for (int i = 0; i < 4; i++)
      swr_master_inst.slot(1'b1, b0);
    start(swr_pkg::ROM_SKIP);
    check(partialByteFlag, 1'b1, "partial");
    sendByte(8'hA3);
    sendByte(8'h2D);
    sendByte(8'h01);
    for (int i = 0; i < 8; i++)
      sendByte(data[8*i +: 8]);
    check({partialByteFlag, targetAddr, spData}, {1'b0, 16'h0128, data}, "rewrite");
    $display("test partial done");
    for (int k = 0; k < 2; k++)
    begin
      start(swr_pkg::ROM_MATCH);
      for (int i = 0; i < 8; i++)
        sendByte(romId[8*i +: 8] ^ {k[0], 7'h00});
      check({functionActive, resumeFlag}, {2{!k[0]}}, "match");
      start(swr_pkg::ROM_RESUME);
      check(functionActive, !k[0], "resume");
    end
    $display("test match done");
    for (int k = 0; k < 2; k++)
    begin
      start(swr_pkg::ROM_SEARCH);
      for (int i = 0; i < (k ? 6 : 64); i++)
      begin
        swr_master_inst.slot(1'b1, b0);
        swr_master_inst.slot(1'b1, b1);
        check({b0, b1}, (k && i > 3) ? 2'b11 : {romId[i], !romId[i]}, "search");
        swr_master_inst.slot(romId[i] ^ (k && i == 3), b0);
      end
      check({functionActive, resumeFlag}, {2{k == 0}}, "search end");
    end
    $display("test search done");
    start(swr_pkg::ROM_HS_SKIP);
    check(highSpeedFlag, 1'b1, "high speed");
    swr_master_inst.busReset(4100, b0);
    check(highSpeedFlag, 1'b0, "speed back");
    $display("test speed done");
    test_done;
  end
endmodule
